// ===== bench/tb_gpio_direction_set_clear.sv
`timescale 1ns/1ps
`default_nettype none

module tb_gpio_direction_set_clear;

  // ==========================================================================
  // Stimulus, observed outputs and expected direction state
  logic        clk;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hresp;
  logic [63:0] pad_in;
  logic [63:0] pad_out;
  logic [63:0] pad_oe;
  logic [63:0] dir;
  logic [63:0] outs;
  logic [31:0] w;
  int          fail_count;
  int          n_compared;
  int          cycles;
  int          k;
  int          h;

  gpio_direction_set_clear #(.ADDR_W(32)) i_dut (
    .I_REF_CLK   (clk),
    .I_SYS_RST   (rst),
    .I_HSEL      (hsel),
    .I_HADDR     (haddr),
    .I_HTRANS    (htrans),
    .I_HWRITE    (hwrite),
    .I_HSIZE     (hsize),
    .I_HWDATA    (hwdata),
    .I_HREADY    (hready),
    .O_HREADYOUT (hready),
    .O_HRDATA    (hrdata),
    .O_HRESP     (hresp),
    .I_PAD_IN    (pad_in),
    .O_PAD_OUT   (pad_out),
    .O_PAD_OE    (pad_oe)
  );

  initial clk = 1'b0;
  always #50 clk = ~clk;

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] ad(input logic [7:0] o);
    return {24'h000000, o};
  endfunction : ad

  // Set and clear ports in a fixed order: set low, set high, clear low, clear high
  function automatic logic [31:0] port_of(input int n);
    case (n)
      0:       return ad(gpio_dir_pkg::OFS_SET_LOW);
      1:       return ad(gpio_dir_pkg::OFS_SET_HIGH);
      2:       return ad(gpio_dir_pkg::OFS_CLR_LOW);
      default: return ad(gpio_dir_pkg::OFS_CLR_HIGH);
    endcase
  endfunction : port_of

  function automatic logic [31:0] next_half(input int n, input logic [31:0] old,
                                            input logic [31:0] wd);
    return (n < 2) ? (old | wd) : (old & ~wd);
  endfunction : next_half

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Entered just after a rising edge; returns just after the data-phase edge
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      input logic [2:0] sz, output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= gpio_dir_pkg::TRANS_NSEQ;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= sz;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, gpio_dir_pkg::SIZE_WORD, r);
  endtask : wr

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h00000000, gpio_dir_pkg::SIZE_WORD, r);
    chk({32'h00000000, r}, {32'h00000000, exp});
  endtask : rdchk

  // Pad enables settle at the data-phase edge, so look one edge later
  task automatic oe_chk();
    @(posedge clk);
    chk(pad_oe, dir);
  endtask : oe_chk

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      summarize();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    rst        = 1'b1;
    hsel       = 1'b0;
    haddr      = 32'h0;
    htrans     = 2'h0;
    hwrite     = 1'b0;
    hsize      = 3'h0;
    hwdata     = 32'h0;
    pad_in     = 64'h0;
    dir        = 64'h0;
    fail_count = 0;
    n_compared = 0;
    cycles     = 0;
    void'($urandom(75));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(pad_oe, 64'h0);
    chk({63'h0, hresp}, 64'h0);
    rdchk(ad(gpio_dir_pkg::OFS_DIR_HIGH), 32'h00000000);
    $display("test reset done");
    for (h = 0; h < 2; h++) begin
      w = $urandom;
      wr(h ? ad(gpio_dir_pkg::OFS_DIR_HIGH) : ad(gpio_dir_pkg::OFS_DIR_LOW), w);
      dir[h*32 +: 32] = w;
      oe_chk();
    end
    rdchk(ad(gpio_dir_pkg::OFS_DIR_LOW), dir[31:0]);
    rdchk(ad(gpio_dir_pkg::OFS_DIR_HIGH), dir[63:32]);
    $display("test direct load done");
    // Zero words, then all-ones words, then random words on every port
    for (int n = 0; n < 48; n++) begin
      k = n % 4;
      h = k % 2;
      w = (n < 4) ? 32'h00000000 : (n < 8) ? 32'hFFFFFFFF : $urandom;
      dir[h*32 +: 32] = next_half(k, dir[h*32 +: 32], w);
      wr(port_of(k), w);
      oe_chk();
      if (n % 5 == 0) begin
        rdchk(port_of(k), 32'h00000000);
        oe_chk();
      end
    end
    $display("test set and clear done");
    w = $urandom;
    dir[31:0] = dir[31:0] | w;
    wr(port_of(0), w);
    rdchk(ad(gpio_dir_pkg::OFS_DIR_LOW), dir[31:0]);
    w = $urandom;
    dir[63:32] = dir[63:32] & ~w;
    wr(port_of(3), w);
    rdchk(ad(gpio_dir_pkg::OFS_DIR_HIGH), dir[63:32]);
    $display("test back to back done");
    wr(32'h00000080, 32'hFFFFFFFF);
    xfer(1'b1, ad(gpio_dir_pkg::OFS_SET_LOW), 32'hFFFFFFFF, 3'h0, w);
    oe_chk();
    rdchk(32'h00000080, 32'h00000000);
    $display("test refused done");
    outs = {$urandom, $urandom};
    wr(ad(gpio_dir_pkg::OFS_OUT_LOW), outs[31:0]);
    wr(ad(gpio_dir_pkg::OFS_OUT_HIGH), outs[63:32]);
    @(posedge clk);
    chk(pad_out, outs);
    pad_in <= {$urandom, $urandom};
    repeat (3) @(posedge clk);
    rdchk(ad(gpio_dir_pkg::OFS_IN_LOW), pad_in[31:0]);
    rdchk(ad(gpio_dir_pkg::OFS_IN_HIGH), pad_in[63:32]);
    oe_chk();
    $display("test pads done");
    summarize();
  end

endmodule : tb_gpio_direction_set_clear

`default_nettype wire

// ===== common/dir_update_if.sv
`timescale 1ns/1ps
`default_nettype none

interface dir_update_if #(parameter int W = 32);
  gpio_dir_pkg::dir_op_t op;
  logic [W-1:0]          word;
  logic [W-1:0]          state;

  modport ctrl (output op, output word, input state);
  modport half (input op, input word, output state);
endinterface : dir_update_if

`default_nettype wire

// ===== common/gpio_dir_pkg.sv
// Function
// - Two write-only direction-set ports exist, one per 32-pad half.
// - A set-port write makes that half the OR of old value and word.
// - Each 1 written to a set port forces its direction bit to 1.
// - A pad is driven as an output whenever its direction bit is 1.
// - Two write-only direction-clear ports exist, one per 32-pad half.
// - A clear-port write makes that half old value AND NOT word.
// - Each 1 written to a clear port forces its direction bit to 0.
// - Software may also write either direction half directly in one access.
// - 64 pads; lower-half bit n is pad n, upper-half bit n is pad n+32.
// - A direction bit of 0 selects input operation for that pad.
`default_nettype none

package gpio_dir_pkg;

  // ==========================================================================
  // Sizes
  localparam int HALF_W    = 32;
  localparam int PAD_COUNT = 64;
  localparam int OFS_W     = 8;

  // ==========================================================================
  // Register offsets
  localparam logic [OFS_W-1:0] OFS_DIR_LOW   = 8'h10;
  localparam logic [OFS_W-1:0] OFS_DIR_HIGH  = 8'h14;
  localparam logic [OFS_W-1:0] OFS_OUT_LOW   = 8'h18;
  localparam logic [OFS_W-1:0] OFS_OUT_HIGH  = 8'h1C;
  localparam logic [OFS_W-1:0] OFS_IN_LOW    = 8'h20;
  localparam logic [OFS_W-1:0] OFS_IN_HIGH   = 8'h24;
  localparam logic [OFS_W-1:0] OFS_SET_LOW   = 8'h58;
  localparam logic [OFS_W-1:0] OFS_SET_HIGH  = 8'h5C;
  localparam logic [OFS_W-1:0] OFS_CLR_LOW   = 8'h60;
  localparam logic [OFS_W-1:0] OFS_CLR_HIGH  = 8'h64;

  // ==========================================================================
  // Reset values and bus codes
  localparam logic [HALF_W-1:0] DIR_RESET  = 32'h00000000;
  localparam logic [HALF_W-1:0] OUT_RESET  = 32'h00000000;
  localparam logic [2:0]        SIZE_WORD  = 3'h2;
  localparam logic [1:0]        TRANS_NSEQ = 2'h2;

  typedef enum {OP_NONE, OP_LOAD, OP_SET, OP_CLEAR} dir_op_t;

  typedef enum {
    SEL_NONE, SEL_DIR_LOW, SEL_DIR_HIGH, SEL_OUT_LOW, SEL_OUT_HIGH,
    SEL_IN_LOW, SEL_IN_HIGH, SEL_SET_LOW, SEL_SET_HIGH, SEL_CLR_LOW, SEL_CLR_HIGH
  } reg_sel_t;

  // ==========================================================================
  // Update of one direction half; shared by the state and the read path
  function automatic logic [HALF_W-1:0] apply_op(input dir_op_t op,
                                                 input logic [HALF_W-1:0] old,
                                                 input logic [HALF_W-1:0] word);
    logic [HALF_W-1:0] res;
    res = old;
    unique case (op)
      OP_NONE:  res = old;
      OP_LOAD:  res = word;
      OP_SET:   res = old | word;
      OP_CLEAR: res = old & ~word;
    endcase
    return res;
  endfunction : apply_op

endpackage : gpio_dir_pkg

`default_nettype wire

// ===== hw/dir_half.sv
`timescale 1ns/1ps
`default_nettype none

module dir_half (
  // Clock and reset
  input  wire logic   i_clk,
  input  wire logic   i_rst,
  // Update request and state
  dir_update_if.half  upd
);

  // ==========================================================================
  // Direction state of one 32-pad half
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      upd.state <= gpio_dir_pkg::DIR_RESET;
    end else begin
      upd.state <= gpio_dir_pkg::apply_op(upd.op, upd.state, upd.word);
    end
  end

  // ==========================================================================
  // Checks
  a_set_keeps_ones: assert property (@(posedge i_clk) disable iff (i_rst)
    upd.op == gpio_dir_pkg::OP_SET |=>
      upd.state == ($past(upd.state) | $past(upd.word)))
    else $error("set port lost or invented a direction bit");

  a_clear_keeps_zeros: assert property (@(posedge i_clk) disable iff (i_rst)
    upd.op == gpio_dir_pkg::OP_CLEAR |=>
      upd.state == ($past(upd.state) & ~$past(upd.word)))
    else $error("clear port lost or invented a direction bit");

endmodule : dir_half

`default_nettype wire

// ===== hw/gpio_direction_set_clear.sv
`timescale 1ns/1ps
`default_nettype none

module gpio_direction_set_clear #(
  parameter int ADDR_W = 32
) (
  // Clock and reset
  input  wire logic                   I_REF_CLK,
  input  wire logic                   I_SYS_RST,
  // AHB-Lite slave
  input  wire logic                   I_HSEL,
  input  wire logic [ADDR_W-1:0]      I_HADDR,
  input  wire logic [1:0]             I_HTRANS,
  input  wire logic                   I_HWRITE,
  input  wire logic [2:0]             I_HSIZE,
  input  wire logic [31:0]            I_HWDATA,
  input  wire logic                   I_HREADY,
  output logic                        O_HREADYOUT,
  output logic [31:0]                 O_HRDATA,
  output logic                        O_HRESP,
  // Pads
  input  wire logic [63:0]            I_PAD_IN,
  output logic      [63:0]            O_PAD_OUT,
  output logic      [63:0]            O_PAD_OE
);

  localparam int HW = gpio_dir_pkg::HALF_W;

  // ==========================================================================
  // Bus phase state
  logic                  data_valid;
  logic                  data_write;
  gpio_dir_pkg::reg_sel_t data_sel;
  gpio_dir_pkg::reg_sel_t addr_sel;
  logic                  addr_take;
  logic [HW-1:0]         next_dir_low;
  logic [HW-1:0]         next_dir_high;
  logic [HW-1:0]         out_low;
  logic [HW-1:0]         out_high;
  logic [HW-1:0]         next_out_low;
  logic [HW-1:0]         next_out_high;
  logic [HW-1:0]         next_rdata;
  logic [63:0]           pad_in_sync;
  logic                  wr_set_low;
  logic                  wr_set_high;
  logic                  wr_clr_low;
  logic                  wr_clr_high;
  logic                  wr_dir_low;
  logic                  wr_dir_high;

  dir_update_if #(.W(HW)) upd_low ();
  dir_update_if #(.W(HW)) upd_high ();

  // ==========================================================================
  // Address decode
  function automatic gpio_dir_pkg::reg_sel_t decode_ofs(input logic [ADDR_W-1:0] addr);
    gpio_dir_pkg::reg_sel_t sel;
    sel = gpio_dir_pkg::SEL_NONE;
    if (addr[ADDR_W-1:gpio_dir_pkg::OFS_W] == '0) begin
      unique case (addr[gpio_dir_pkg::OFS_W-1:0])
        gpio_dir_pkg::OFS_DIR_LOW:  sel = gpio_dir_pkg::SEL_DIR_LOW;
        gpio_dir_pkg::OFS_DIR_HIGH: sel = gpio_dir_pkg::SEL_DIR_HIGH;
        gpio_dir_pkg::OFS_OUT_LOW:  sel = gpio_dir_pkg::SEL_OUT_LOW;
        gpio_dir_pkg::OFS_OUT_HIGH: sel = gpio_dir_pkg::SEL_OUT_HIGH;
        gpio_dir_pkg::OFS_IN_LOW:   sel = gpio_dir_pkg::SEL_IN_LOW;
        gpio_dir_pkg::OFS_IN_HIGH:  sel = gpio_dir_pkg::SEL_IN_HIGH;
        gpio_dir_pkg::OFS_SET_LOW:  sel = gpio_dir_pkg::SEL_SET_LOW;
        gpio_dir_pkg::OFS_SET_HIGH: sel = gpio_dir_pkg::SEL_SET_HIGH;
        gpio_dir_pkg::OFS_CLR_LOW:  sel = gpio_dir_pkg::SEL_CLR_LOW;
        gpio_dir_pkg::OFS_CLR_HIGH: sel = gpio_dir_pkg::SEL_CLR_HIGH;
        default:                    sel = gpio_dir_pkg::SEL_NONE;
      endcase
    end
    return sel;
  endfunction : decode_ofs

  // Only whole-word transfers reach the registers; other sizes are dropped
  assign addr_take = I_HSEL && I_HREADY && (I_HTRANS == gpio_dir_pkg::TRANS_NSEQ);
  assign addr_sel  = (I_HSIZE == gpio_dir_pkg::SIZE_WORD) ? decode_ofs(I_HADDR)
                                                         : gpio_dir_pkg::SEL_NONE;

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      data_valid <= 1'b0;
      data_write <= 1'b0;
      data_sel   <= gpio_dir_pkg::SEL_NONE;
    end else begin
      data_valid <= addr_take;
      data_write <= addr_take && I_HWRITE;
      data_sel   <= addr_take ? addr_sel : gpio_dir_pkg::SEL_NONE;
    end
  end

  // Zero-wait slave: every transfer completes in its first data cycle
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP     = 1'b0;

  // ==========================================================================
  // Write strobes in the data phase
  assign wr_set_low  = data_write && (data_sel == gpio_dir_pkg::SEL_SET_LOW);
  assign wr_set_high = data_write && (data_sel == gpio_dir_pkg::SEL_SET_HIGH);
  assign wr_clr_low  = data_write && (data_sel == gpio_dir_pkg::SEL_CLR_LOW);
  assign wr_clr_high = data_write && (data_sel == gpio_dir_pkg::SEL_CLR_HIGH);
  assign wr_dir_low  = data_write && (data_sel == gpio_dir_pkg::SEL_DIR_LOW);
  assign wr_dir_high = data_write && (data_sel == gpio_dir_pkg::SEL_DIR_HIGH);

  always_comb begin
    upd_low.word  = I_HWDATA;
    upd_high.word = I_HWDATA;
    upd_low.op    = gpio_dir_pkg::OP_NONE;
    upd_high.op   = gpio_dir_pkg::OP_NONE;
    if (wr_dir_low) begin
      upd_low.op = gpio_dir_pkg::OP_LOAD;
    end else if (wr_set_low) begin
      upd_low.op = gpio_dir_pkg::OP_SET;
    end else if (wr_clr_low) begin
      upd_low.op = gpio_dir_pkg::OP_CLEAR;
    end
    if (wr_dir_high) begin
      upd_high.op = gpio_dir_pkg::OP_LOAD;
    end else if (wr_set_high) begin
      upd_high.op = gpio_dir_pkg::OP_SET;
    end else if (wr_clr_high) begin
      upd_high.op = gpio_dir_pkg::OP_CLEAR;
    end
  end

  dir_half u_dir_low (
    .i_clk (I_REF_CLK),
    .i_rst (I_SYS_RST),
    .upd   (upd_low.half)
  );

  dir_half u_dir_high (
    .i_clk (I_REF_CLK),
    .i_rst (I_SYS_RST),
    .upd   (upd_high.half)
  );

  // ==========================================================================
  // Pad output data
  always_comb begin
    next_out_low  = out_low;
    next_out_high = out_high;
    if (data_write && data_sel == gpio_dir_pkg::SEL_OUT_LOW) begin
      next_out_low = I_HWDATA;
    end
    if (data_write && data_sel == gpio_dir_pkg::SEL_OUT_HIGH) begin
      next_out_high = I_HWDATA;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      out_low  <= gpio_dir_pkg::OUT_RESET;
      out_high <= gpio_dir_pkg::OUT_RESET;
    end else begin
      out_low  <= next_out_low;
      out_high <= next_out_high;
    end
  end

  // Pad n takes lower-half bit n, pad n+32 upper-half bit n
  assign O_PAD_OUT = {out_high, out_low};
  assign O_PAD_OE  = {upd_high.state, upd_low.state};

  pad_sync #(.W(gpio_dir_pkg::PAD_COUNT)) u_pad_sync (
    .i_clk   (I_REF_CLK),
    .i_rst   (I_SYS_RST),
    .i_async (I_PAD_IN),
    .o_sync  (pad_in_sync)
  );

  // ==========================================================================
  // Read path
  // Read data is sampled from the next values so that a read right after a
  // write to the same register sees the written result, not the old one.
  assign next_dir_low  = gpio_dir_pkg::apply_op(upd_low.op, upd_low.state, I_HWDATA);
  assign next_dir_high = gpio_dir_pkg::apply_op(upd_high.op, upd_high.state, I_HWDATA);

  always_comb begin
    next_rdata = '0;
    if (addr_take && !I_HWRITE) begin
      unique case (addr_sel)
        gpio_dir_pkg::SEL_DIR_LOW:  next_rdata = next_dir_low;
        gpio_dir_pkg::SEL_DIR_HIGH: next_rdata = next_dir_high;
        gpio_dir_pkg::SEL_OUT_LOW:  next_rdata = next_out_low;
        gpio_dir_pkg::SEL_OUT_HIGH: next_rdata = next_out_high;
        gpio_dir_pkg::SEL_IN_LOW:   next_rdata = pad_in_sync[HW-1:0];
        gpio_dir_pkg::SEL_IN_HIGH:  next_rdata = pad_in_sync[63:HW];
        // Set and clear ports, and unmapped words, read as zero
        gpio_dir_pkg::SEL_SET_LOW,
        gpio_dir_pkg::SEL_SET_HIGH,
        gpio_dir_pkg::SEL_CLR_LOW,
        gpio_dir_pkg::SEL_CLR_HIGH,
        gpio_dir_pkg::SEL_NONE:     next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      O_HRDATA <= '0;
    end else begin
      O_HRDATA <= next_rdata;
    end
  end

  // ==========================================================================
  // Checks
  a_set_low_or: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    wr_set_low |=> O_PAD_OE[31:0] == ($past(O_PAD_OE[31:0]) | $past(I_HWDATA)))
    else $error("set of lower half is not an OR");

  a_set_high_pads: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    wr_set_high |=> ((O_PAD_OE[63:32] & $past(I_HWDATA)) == $past(I_HWDATA))
      && (O_PAD_OE[31:0] == $past(O_PAD_OE[31:0])))
    else $error("upper set port hit the wrong pads");

  a_clear_low_and: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    wr_clr_low |=> O_PAD_OE[31:0] == ($past(O_PAD_OE[31:0]) & ~$past(I_HWDATA)))
    else $error("clear of lower half is not an AND NOT");

  a_clear_high_input: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    wr_clr_high |=> (O_PAD_OE[63:32] & $past(I_HWDATA)) == '0)
    else $error("cleared pad still driven");

  a_direct_load: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    wr_dir_high |=> O_PAD_OE[63:32] == $past(I_HWDATA))
    else $error("direct write of upper half not loaded");

  a_port_read_zero: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    addr_take && !I_HWRITE && (addr_sel inside {gpio_dir_pkg::SEL_SET_LOW,
      gpio_dir_pkg::SEL_SET_HIGH, gpio_dir_pkg::SEL_CLR_LOW,
      gpio_dir_pkg::SEL_CLR_HIGH}) && !data_write
      |=> O_HRDATA == '0 ##1 $stable(O_PAD_OE))
    else $error("read of a set or clear port was not zero or had an effect");

  a_dir_readback: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    addr_take && !I_HWRITE && addr_sel == gpio_dir_pkg::SEL_DIR_LOW
      |=> O_HRDATA == O_PAD_OE[31:0])
    else $error("direction readback differs from driven enables");

  a_quiet_holds: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    !data_write ##1 !data_write |-> $stable(O_PAD_OE))
    else $error("direction changed with no write");

  a_set_clear_split: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    wr_clr_high |=> O_PAD_OE[31:0] == $past(O_PAD_OE[31:0]))
    else $error("upper clear port touched the lower half");

  a_set_high_or: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    wr_set_high |=> O_PAD_OE[63:32] == ($past(O_PAD_OE[63:32]) | $past(I_HWDATA)))
    else $error("set of upper half is not an OR");

  a_clear_high_and: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    wr_clr_high |=> O_PAD_OE[63:32] == ($past(O_PAD_OE[63:32]) & ~$past(I_HWDATA)))
    else $error("clear of upper half is not an AND NOT");

  a_set_low_drives: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    wr_set_low |=> (O_PAD_OE[31:0] & $past(I_HWDATA)) == $past(I_HWDATA))
    else $error("set lower pad not driven as output");

  a_clear_low_input: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    wr_clr_low |=> (O_PAD_OE[31:0] & $past(I_HWDATA)) == '0)
    else $error("cleared lower pad still driven");

  a_direct_load_low: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    wr_dir_low |=> O_PAD_OE[31:0] == $past(I_HWDATA))
    else $error("direct write of lower half not loaded");

  // A lower-port write that also changed the upper half would still pass the per-half value checks above
  a_low_port_split: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (wr_set_low || wr_clr_low || wr_dir_low)
      |=> O_PAD_OE[63:32] == $past(O_PAD_OE[63:32]))
    else $error("lower port touched the upper half");

  a_high_readback: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    addr_take && !I_HWRITE && addr_sel == gpio_dir_pkg::SEL_DIR_HIGH
      |=> O_HRDATA == O_PAD_OE[63:32])
    else $error("upper direction readback differs from driven enables");

  // ==========================================================================
  // Checks of write side effects
  // Port writes never stall or error, so software may issue them back to back
  a_port_write_okay: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    data_valid && (data_sel inside {gpio_dir_pkg::SEL_SET_LOW, gpio_dir_pkg::SEL_SET_HIGH,
      gpio_dir_pkg::SEL_CLR_LOW, gpio_dir_pkg::SEL_CLR_HIGH})
      |-> O_HREADYOUT && !O_HRESP)
    else $error("set or clear port write was stalled or refused");

  a_set_keeps_data: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (wr_set_low || wr_set_high) |=> $stable(O_PAD_OUT))
    else $error("set port changed pad output data");

  a_clear_keeps_data: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (wr_clr_low || wr_clr_high) |=> $stable(O_PAD_OUT))
    else $error("clear port changed pad output data");

  // Unmapped words and narrow sizes must leave every pad alone
  a_refused_quiet: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    data_write && data_sel == gpio_dir_pkg::SEL_NONE
      |=> $stable(O_PAD_OE) && $stable(O_PAD_OUT))
    else $error("refused write changed a pad");

endmodule : gpio_direction_set_clear

`default_nettype wire

// ===== hw/pad_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pad_sync #(
  parameter int W = 64
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Asynchronous pad levels and synchronised copy
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] stage1;

  // ==========================================================================
  // Two flops; the first is read only by the second
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule : pad_sync

`default_nettype wire
